// *** ocpc_pkg.sv ***
// constants for the output compare pulse channel block
`default_nettype none
package ocpc_pkg;
   localparam int OCPC_NCH = 8;
   localparam int OCPC_DW = 16;
   // byte offsets: per channel a block of four words
   localparam logic [7:0] OCPC_CH_STRIDE = 8'h10;
   localparam logic [3:0] OCPC_OFS_CTRL = 4'h0;
   localparam logic [3:0] OCPC_OFS_PRI = 4'h4;
   localparam logic [3:0] OCPC_OFS_SEC = 4'h8;
   localparam logic [7:0] OCPC_OFS_STAT = 8'h80;
   localparam logic [7:0] OCPC_OFS_MASK = 8'h84;
   localparam logic [7:0] OCPC_OFS_PIN = 8'h88;
   localparam int OCPC_TSEL_BIT = 3;
   localparam int OCPC_MODE_HI = 2;
   localparam logic [15:0] OCPC_CTRL_RST = 16'h0000;
   localparam logic [15:0] OCPC_CMP_RST = 16'h0000;
   localparam logic [2:0] OCPC_M_OFF = 3'h0;
   localparam logic [2:0] OCPC_M_LOW = 3'h1;
   localparam logic [2:0] OCPC_M_HIGH = 3'h2;
   localparam logic [2:0] OCPC_M_TOG = 3'h3;
   localparam logic [2:0] OCPC_M_SINGLE = 3'h4;
   localparam logic [2:0] OCPC_M_CONT = 3'h5;
   localparam logic [1:0] OCPC_RESP_OK = 2'h0;
   localparam logic [1:0] OCPC_RESP_ERR = 2'h2;
   typedef enum logic [1:0] {OCPC_P_IDLE, OCPC_P_WAIT_HI, OCPC_P_WAIT_LO, OCPC_P_DONE} ocpc_pst_t;
endpackage
`default_nettype wire

// *** ocpc_chan.sv ***
// one compare channel: match detection and pin action
`default_nettype none
module ocpc_chan
   import ocpc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [15:0] ctrl,
   input wire logic mode_wr,
   input wire logic [15:0] cmp_pri,
   input wire logic [15:0] cmp_sec,
   input wire logic [15:0] cnt_a,
   input wire logic [15:0] cnt_b,
   output logic pin,
   output logic evt
);
   logic [2:0] mode;
   logic [15:0] cnt;
   logic m_pri, m_sec;
   ocpc_pst_t pst_r;
   assign mode = ctrl[OCPC_MODE_HI:0];
   assign cnt = ctrl[OCPC_TSEL_BIT] ? cnt_b : cnt_a; // R02
   // equality only: a counter wrap below the value leaves the pin alone
   assign m_pri = (cnt == cmp_pri); // R04 R05
   assign m_sec = (cnt == cmp_sec); // R06

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin <= 1'b0;
         evt <= 1'b0;
         pst_r <= OCPC_P_IDLE;
      end else if (ce) begin
         evt <= 1'b0;
         if (mode_wr) begin
            // rewriting a pulse mode rearms the sequence
            pst_r <= OCPC_P_WAIT_HI; // R07
         end else begin
            case (mode)
               OCPC_M_LOW, OCPC_M_HIGH, OCPC_M_TOG: begin // R03
                  if (m_pri) begin
                     evt <= 1'b1; // R11
                     if (mode == OCPC_M_LOW) pin <= 1'b0;
                     else if (mode == OCPC_M_HIGH) pin <= 1'b1;
                     else pin <= ~pin;
                  end
               end
               OCPC_M_SINGLE, OCPC_M_CONT: begin
                  case (pst_r)
                     OCPC_P_WAIT_HI: begin
                        if (m_pri) begin
                           pin <= 1'b1; // R06
                           evt <= 1'b1;
                           pst_r <= OCPC_P_WAIT_LO;
                        end
                     end
                     OCPC_P_WAIT_LO: begin
                        if (m_sec) begin
                           pin <= 1'b0; // R06
                           evt <= 1'b1;
                           pst_r <= (mode == OCPC_M_CONT) ? OCPC_P_WAIT_HI : OCPC_P_DONE; // R08 R13
                        end
                     end
                     OCPC_P_DONE: pin <= 1'b0; // R13
                     default: pst_r <= OCPC_P_WAIT_HI;
                  endcase
               end
               default: pst_r <= OCPC_P_IDLE; // R12
            endcase
         end
      end
   end

   ocpc_dly_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !mode_wr && mode == OCPC_M_HIGH && m_pri |=> pin && evt) // R03
      else $error("high on match missing");
   sgl_end_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !mode_wr && mode == OCPC_M_SINGLE && pst_r == OCPC_P_WAIT_LO && m_sec
      |=> !pin && pst_r == OCPC_P_DONE) // R13
      else $error("single pulse did not end");
   off_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && mode == OCPC_M_OFF |=> !evt && $stable(pin)) // R12
      else $error("disabled channel acted");
   no_match_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && mode == OCPC_M_TOG && !m_pri && !mode_wr |=> $stable(pin)) // R05
      else $error("pin moved without match");
   cont_rearm_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && !mode_wr && mode == OCPC_M_CONT && pst_r == OCPC_P_WAIT_LO && m_sec
      |=> pst_r == OCPC_P_WAIT_HI) // R08
      else $error("continuous pulse not rearmed");
endmodule
`default_nettype wire

// *** ocpc_axil.sv ***
// axi4-lite slave front end: one write and one read at a time
`default_nettype none
module ocpc_axil
   import ocpc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_go,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_have_r, w_have_r;
   logic [7:0] ar_addr_r;
   logic ar_have_r;
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   assign rd_addr = ar_addr_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= OCPC_RESP_OK;
      end else if (ce) begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? OCPC_RESP_OK : OCPC_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ar_have_r <= 1'b0;
         ar_addr_r <= 8'h00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= OCPC_RESP_OK;
      end else if (ce) begin
         s_axi_arready <= !ar_have_r && !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            ar_have_r <= 1'b1;
            ar_addr_r <= s_axi_araddr;
         end
         if (ar_have_r) begin
            ar_have_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? OCPC_RESP_OK : OCPC_RESP_ERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** ocpc_top.sv ***
// output compare block: eight channels, registers and interrupt
// Behaviour
// (R01) eight independent channels, each with control, primary, secondary and pin
// (R02) control bit 3 picks timer b, else timer a; timer a after reset
// (R03) mode 001 drives low, 010 high, 011 toggles on match
// (R04) simple modes compare primary value with selected timer count
// (R05) timer wrapping before primary match leaves pin unchanged
// (R06) pulse modes: primary match raises pin, secondary match lowers it
// (R07) mode 100 gives one pulse; rewriting 100 arms another
// (R08) mode 101 repeats one pulse each timer period
// (R09) software loads times and period, then mode, then starts timer
// (R10) mode and timebase sit in one writable 16-bit control register
// (R11) each compare event sets a sticky flag until software clears it
// (R12) mode 000 disables the channel: no pin action, no events
// (R13) after single pulse ends pin stays low until 100 rewritten
`default_nettype none
module ocpc_top
   import ocpc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [15:0] timer_a_count,
   input wire logic [15:0] timer_b_count,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] compare_output_pin,
   output logic irq
);
   logic wr_go, wr_ok, rd_ok;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [15:0] compare_control_r [OCPC_NCH];
   logic [15:0] compare_primary_r [OCPC_NCH];
   logic [15:0] compare_secondary_r [OCPC_NCH];
   logic [7:0] compare_irq_flag_r, irq_mask_r, evt, pin_w, mode_wr;
   logic [15:0] ta_s1_r, ta_s2_r, tb_s1_r, tb_s2_r;
   logic [2:0] wr_ch, rd_ch;
   logic wr_in_ch, rd_in_ch, stat_wr, mask_wr;

   // timer counts come from another block; two stages before any compare
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ta_s1_r <= 16'h0000;
         ta_s2_r <= 16'h0000;
         tb_s1_r <= 16'h0000;
         tb_s2_r <= 16'h0000;
      end else if (ce) begin
         ta_s1_r <= timer_a_count;
         ta_s2_r <= ta_s1_r;
         tb_s1_r <= timer_b_count;
         tb_s2_r <= tb_s1_r;
      end
   end

   ocpc_axil u_bus (
      .clk(clk), .rstn(rstn), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .wr_go(wr_go), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
   );

   assign wr_in_ch = (wr_addr < OCPC_OFS_STAT) && (wr_addr[3:0] != 4'hC) && (wr_addr[1:0] == 2'b00);
   assign rd_in_ch = (rd_addr < OCPC_OFS_STAT) && (rd_addr[3:0] != 4'hC) && (rd_addr[1:0] == 2'b00);
   assign wr_ch = wr_addr[6:4];
   assign rd_ch = rd_addr[6:4];
   assign stat_wr = wr_go && ce && wr_addr == OCPC_OFS_STAT && wr_strb[0];
   assign mask_wr = wr_go && ce && wr_addr == OCPC_OFS_MASK && wr_strb[0];
   assign wr_ok = wr_in_ch || wr_addr == OCPC_OFS_STAT || wr_addr == OCPC_OFS_MASK;
   assign rd_ok = rd_in_ch || rd_addr == OCPC_OFS_STAT || rd_addr == OCPC_OFS_MASK
      || rd_addr == OCPC_OFS_PIN;

   always_comb begin
      rd_data = 32'h0000_0000;
      if (rd_in_ch) begin
         if (rd_addr[3:0] == OCPC_OFS_CTRL) rd_data = {16'h0000, compare_control_r[rd_ch]};
         else if (rd_addr[3:0] == OCPC_OFS_PRI) rd_data = {16'h0000, compare_primary_r[rd_ch]};
         else rd_data = {16'h0000, compare_secondary_r[rd_ch]};
      end else if (rd_addr == OCPC_OFS_STAT) begin
         rd_data = {24'h000000, compare_irq_flag_r};
      end else if (rd_addr == OCPC_OFS_MASK) begin
         rd_data = {24'h000000, irq_mask_r};
      end else if (rd_addr == OCPC_OFS_PIN) begin
         rd_data = {24'h000000, compare_output_pin};
      end
   end

   genvar g;
   generate
      for (g = 0; g < OCPC_NCH; g++) begin : g_ch // R01
         logic sel_w;
         assign sel_w = wr_go && ce && wr_in_ch && wr_ch == 3'(g);
         // a control write that carries a pulse mode restarts the pulse sequence
         assign mode_wr[g] = sel_w && wr_addr[3:0] == OCPC_OFS_CTRL && wr_strb[0]; // R07

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               compare_control_r[g] <= OCPC_CTRL_RST; // R02
               compare_primary_r[g] <= OCPC_CMP_RST;
               compare_secondary_r[g] <= OCPC_CMP_RST;
            end else if (sel_w) begin
               if (wr_addr[3:0] == OCPC_OFS_CTRL) begin // R10
                  if (wr_strb[0]) compare_control_r[g][7:0] <= wr_data[7:0];
                  if (wr_strb[1]) compare_control_r[g][15:8] <= wr_data[15:8];
               end else if (wr_addr[3:0] == OCPC_OFS_PRI) begin
                  if (wr_strb[0]) compare_primary_r[g][7:0] <= wr_data[7:0];
                  if (wr_strb[1]) compare_primary_r[g][15:8] <= wr_data[15:8];
               end else begin
                  if (wr_strb[0]) compare_secondary_r[g][7:0] <= wr_data[7:0];
                  if (wr_strb[1]) compare_secondary_r[g][15:8] <= wr_data[15:8];
               end
            end
         end

         ocpc_chan u_chan (
            .clk(clk), .rstn(rstn), .ce(ce),
            .ctrl(compare_control_r[g]), .mode_wr(mode_wr[g]),
            .cmp_pri(compare_primary_r[g]), .cmp_sec(compare_secondary_r[g]),
            .cnt_a(ta_s2_r), .cnt_b(tb_s2_r),
            .pin(pin_w[g]), .evt(evt[g])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         compare_irq_flag_r <= 8'h00;
      end else if (ce) begin
         // a new event wins over a same-cycle clear
         compare_irq_flag_r <= (compare_irq_flag_r & ~(stat_wr ? wr_data[7:0] : 8'h00)) | evt; // R11
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_r <= 8'h00;
      end else if (mask_wr) begin
         irq_mask_r <= wr_data[7:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
         compare_output_pin <= 8'h00;
      end else if (ce) begin
         irq <= |((compare_irq_flag_r & ~(stat_wr ? wr_data[7:0] : 8'h00) | evt) & irq_mask_r);
         compare_output_pin <= pin_w;
      end
   end

   flag_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && evt[0] |=> compare_irq_flag_r[0]) // R11
      else $error("event flag not set");
   flag_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      compare_irq_flag_r[0] && !stat_wr |=> compare_irq_flag_r[0]) // R11
      else $error("flag dropped without clear");
   ctrl_store_a: assert property (@(posedge clk) disable iff (!rstn)
      mode_wr[0] && wr_strb[1] |=> compare_control_r[0] == wr_data[15:0]) // R10
      else $error("control write lost");
endmodule
`default_nettype wire

// *** ocpc_tmr.sv ***
// incrementing timer model driving the compare channels
`default_nettype none
module ocpc_tmr
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [15:0] period,
   output logic [15:0] count
);
   timeunit 1ns;
   timeprecision 1ps;
   // a stopped timer reads zero so every run starts from 0x0000
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= 16'h0000;
      end else if (!run) begin
         count <= 16'h0000;
      end else if (count >= period) begin
         count <= 16'h0000;
      end else begin
         count <= count + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// *** tb_ocpc_top.sv ***
// self-checking bench for the output compare block
`default_nettype none
module tb_ocpc_top
   import ocpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, ce, timer_run_bit, irq;
   logic [15:0] timer_a_count, timer_b_count;
   logic [7:0] s_axi_awaddr, s_axi_araddr, compare_output_pin;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int mismatches = 0;
   int checked = 0;
   typedef struct {logic [2:0] ch; logic [15:0] ctrl, pri, sec; logic pin; int rise; logic flag;} ocpc_row_t;
   // timer a wraps every 65 cycles, timer b every 9: a window of 190 sees three periods of a
   ocpc_row_t rows [10] = '{
      '{3'h0, 16'h0002, 16'h000A, 16'h0000, 1'b1, 1, 1'b1},
      '{3'h0, 16'h0001, 16'h000A, 16'h0000, 1'b0, 0, 1'b1},
      '{3'h1, 16'h0003, 16'h0005, 16'h0000, 1'b1, 2, 1'b1},
      '{3'h2, 16'h000A, 16'h0020, 16'h0000, 1'b0, 0, 1'b0},
      '{3'h3, 16'h0002, 16'h0020, 16'h0000, 1'b1, 1, 1'b1},
      '{3'h4, 16'h000A, 16'h0005, 16'h0000, 1'b1, 1, 1'b1},
      '{3'h5, 16'h0000, 16'h0005, 16'h0000, 1'b0, 0, 1'b0},
      '{3'h6, 16'h0004, 16'h0005, 16'h000A, 1'b0, 1, 1'b1},
      '{3'h7, 16'h0005, 16'h0005, 16'h000A, 1'b0, 3, 1'b1},
      '{3'h6, 16'h0004, 16'h0005, 16'h000A, 1'b0, 1, 1'b1}};

   ocpc_top i_ocpc_top (.clk, .rstn, .ce, .timer_a_count, .timer_b_count,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .compare_output_pin, .irq);
   ocpc_tmr i_ocpc_tmr_a (.clk, .rstn, .run(timer_run_bit), .period(16'h0040), .count(timer_a_count));
   ocpc_tmr i_ocpc_tmr_b (.clk, .rstn, .run(timer_run_bit), .period(16'h0008), .count(timer_b_count));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge clk);
      while (s_axi_arready !== 1'b1) @(posedge clk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk("bresp", 32'h0, {30'h0, r});
   endtask

   task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(nm, e, d);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic prev;
      int rises;
      {rstn, timer_run_bit, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      ce = 1'b1;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // stopped timers, then times, then mode, then run
      foreach (rows[i]) begin
         timer_run_bit <= 1'b0;
         wr(OCPC_OFS_STAT, 32'h0000_00FF);
         wr({1'b0, rows[i].ch, OCPC_OFS_PRI}, {16'h0000, rows[i].pri});
         wr({1'b0, rows[i].ch, OCPC_OFS_SEC}, {16'h0000, rows[i].sec});
         wr({1'b0, rows[i].ch, OCPC_OFS_CTRL}, {16'h0000, rows[i].ctrl});
         @(posedge clk);
         timer_run_bit <= 1'b1;
         rises = 0;
         prev = compare_output_pin[rows[i].ch];
         repeat (190) begin
            @(posedge clk);
            if (compare_output_pin[rows[i].ch] === 1'b1 && prev === 1'b0) rises++;
            prev = compare_output_pin[rows[i].ch];
         end
         chk("pin", {31'h0, rows[i].pin}, {31'h0, compare_output_pin[rows[i].ch]});
         chk("rises", rows[i].rise, rises);
         axi_rd(OCPC_OFS_STAT, d, r);
         chk("flag", {31'h0, rows[i].flag}, {31'h0, d[rows[i].ch]});
         $display("row %0d done", i);
      end
      // interrupt raised, masked, cleared; other channels masked off
      timer_run_bit <= 1'b0;
      wr(OCPC_OFS_STAT, 32'h0000_00FF);
      wr(OCPC_OFS_MASK, 32'h0000_0001);
      wr({4'h0, OCPC_OFS_CTRL}, {29'h0, OCPC_M_TOG});
      @(posedge clk);
      timer_run_bit <= 1'b1;
      repeat (30) @(posedge clk);
      timer_run_bit <= 1'b0;
      chk("irq set", 32'h1, {31'h0, irq});
      axi_rd(OCPC_OFS_PIN, d, r);
      chk("pin readback", 32'h1, {31'h0, d[0]});
      wr(OCPC_OFS_MASK, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OCPC_OFS_MASK, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk("irq sticky", 32'h1, {31'h0, irq});
      wr(OCPC_OFS_STAT, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("interrupt test done");
      // refused addresses and control width
      axi_wr(8'h0C, 32'h0000_0001, r);
      chk("bresp unmapped", {30'h0, OCPC_RESP_ERR}, {30'h0, r});
      axi_rd(8'h8C, d, r);
      chk("rresp unmapped", {30'h0, OCPC_RESP_ERR}, {30'h0, r});
      chk("rdata unmapped", 32'h0, d);
      wr({4'h5, OCPC_OFS_CTRL}, 32'h1234_F5A0);
      rd({4'h5, OCPC_OFS_CTRL}, "ctrl width", 32'h0000_F5A0);
      $display("register test done");
      // enable low: timers keep running, yet no channel pin may move
      d = {24'h0, compare_output_pin};
      ce <= 1'b0;
      timer_run_bit <= 1'b1;
      repeat (40) @(posedge clk);
      chk("pins frozen", d, {24'h0, compare_output_pin});
      ce <= 1'b1;
      timer_run_bit <= 1'b0;
      @(posedge clk);
      $display("enable test done");
      // second reset in mid-run
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      chk("pins in reset", 32'h0, {24'h0, compare_output_pin});
      chk("irq in reset", 32'h0, {31'h0, irq});
      rstn <= 1'b1;
      rd({4'h0, OCPC_OFS_CTRL}, "ctrl reset", 32'h0);
      rd({4'h0, OCPC_OFS_PRI}, "pri reset", 32'h0);
      $display("reset test done");
      report_and_stop();
   end

   // whole run needs about 2300 cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      $display("watchdog expired");
      report_and_stop();
   end
endmodule
`default_nettype wire
